// ### design/sepr_router.sv
module sepr_router
	import sepr_pkg::*;
#(
	parameter int NUM_PINS = 2
)
(
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	input  wire logic       src_any_motion,
	input  wire logic       src_no_motion,
	input  wire logic       src_error,
	input  wire logic       src_fifo_full,
	input  wire logic       src_fifo_level,
	input  wire logic       src_sample_fresh,
	input  wire logic       status_read,
	input  wire logic       event_pin_a_in,
	output logic            event_pin_a_out,
	output logic            event_pin_a_oe,
	output logic            pin_a_in_event,
	input  wire logic       event_pin_b_in,
	output logic            event_pin_b_out,
	output logic            event_pin_b_oe,
	output logic            pin_b_in_event,
	output logic            boot_start,
	output logic      [7:0] boot_load_value
);

	// ==========================================================
	// Register storage
	logic [7:0] pin_a_io_config_reg;
	logic [7:0] pin_b_io_config_reg;
	logic [7:0] event_hold_mode_reg;
	logic [7:0] pin_a_feature_routing_reg;
	logic [7:0] pin_b_feature_routing_reg;
	logic [7:0] hardware_event_routing_reg;
	logic [7:0] boot_load_control_reg;
	logic [7:0] reg_rdata_reg;
	logic [7:0] reg_rdata_next;
	logic       boot_start_reg;

	// ==========================================================
	// Address decode
	logic wr_pin_a_io;
	logic wr_pin_b_io;
	logic wr_hold;
	logic wr_pin_a_feat;
	logic wr_pin_b_feat;
	logic wr_hw_route;
	logic wr_boot;

	// Write strobes per register
	assign wr_pin_a_io   = reg_wr & (reg_addr == SEPR_OFS_PIN_A_IO);
	assign wr_pin_b_io   = reg_wr & (reg_addr == SEPR_OFS_PIN_B_IO);
	assign wr_hold       = reg_wr & (reg_addr == SEPR_OFS_HOLD_MODE);
	assign wr_pin_a_feat = reg_wr & (reg_addr == SEPR_OFS_PIN_A_FEATURE);
	assign wr_pin_b_feat = reg_wr & (reg_addr == SEPR_OFS_PIN_B_FEATURE);
	assign wr_hw_route   = reg_wr & (reg_addr == SEPR_OFS_HW_ROUTING);
	assign wr_boot       = reg_wr & (reg_addr == SEPR_OFS_BOOT_LOAD);

	// Read data select; unmapped addresses return zero
	always_comb
	begin
		case (reg_addr)
			SEPR_OFS_PIN_A_IO:      reg_rdata_next = pin_a_io_config_reg;
			SEPR_OFS_PIN_B_IO:      reg_rdata_next = pin_b_io_config_reg;
			SEPR_OFS_HOLD_MODE:     reg_rdata_next = event_hold_mode_reg;
			SEPR_OFS_PIN_A_FEATURE: reg_rdata_next = pin_a_feature_routing_reg;
			SEPR_OFS_PIN_B_FEATURE: reg_rdata_next = pin_b_feature_routing_reg;
			SEPR_OFS_HW_ROUTING:    reg_rdata_next = hardware_event_routing_reg;
			SEPR_OFS_BOOT_LOAD:     reg_rdata_next = boot_load_control_reg;
			default:                reg_rdata_next = 8'h00;
		endcase
	end

	// ==========================================================
	// Register writes, reserved bits masked to zero
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			pin_a_io_config_reg        <= SEPR_RST_IO;
			pin_b_io_config_reg        <= SEPR_RST_IO;
			event_hold_mode_reg        <= SEPR_RST_HOLD;
			pin_a_feature_routing_reg  <= SEPR_RST_FEATURE;
			pin_b_feature_routing_reg  <= SEPR_RST_FEATURE;
			hardware_event_routing_reg <= SEPR_RST_HW_ROUTE;
		end
		else
		begin
			if (wr_pin_a_io)
				pin_a_io_config_reg <= reg_wdata & SEPR_MASK_IO;
			if (wr_pin_b_io)
				pin_b_io_config_reg <= reg_wdata & SEPR_MASK_IO;
			if (wr_hold)
				event_hold_mode_reg <= reg_wdata & SEPR_MASK_HOLD;
			if (wr_pin_a_feat)
				pin_a_feature_routing_reg <= reg_wdata & SEPR_MASK_FEATURE;
			if (wr_pin_b_feat)
				pin_b_feature_routing_reg <= reg_wdata & SEPR_MASK_FEATURE;
			if (wr_hw_route)
				hardware_event_routing_reg <= reg_wdata & SEPR_MASK_HW_ROUTE;
		end
	end

	// Boot load control: stored value plus start pulse on write
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			boot_load_control_reg <= SEPR_RST_BOOT_LOAD;
			boot_start_reg        <= 1'b0;
		end
		else
		begin
			if (wr_boot)
				boot_load_control_reg <= reg_wdata & SEPR_MASK_BOOT_LOAD;
			boot_start_reg <= wr_boot;
		end
	end

	// Read data register, updated on a read strobe
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			reg_rdata_reg <= 8'h00;
		else if (reg_rd)
			reg_rdata_reg <= reg_rdata_next;
	end

	assign reg_rdata       = reg_rdata_reg;
	assign boot_start      = boot_start_reg;
	assign boot_load_value = boot_load_control_reg;

	// ==========================================================
	// Source routing per pin
	// Each source is gated by its own route bit, then all are ORed.
	// Routing is purely combinational so a source change reaches
	// the pin driver flop in the same cycle; latching adds no delay.
	logic [NUM_PINS-1:0] feat_any_a;
	logic [7:0]          feat_cfg [NUM_PINS];
	logic [2:0]          hw_cfg   [NUM_PINS];
	logic [NUM_PINS-1:0] feat_hit;
	logic [NUM_PINS-1:0] hw_hit;
	logic                pin_a_fifo_full_route;
	logic                pin_a_fifo_level_route;
	logic                pin_a_sample_fresh_route;
	logic                pin_b_fifo_full_route;
	logic                pin_b_fifo_level_route;
	logic                pin_b_sample_fresh_route;

	// Hardware event routing fields
	assign pin_a_fifo_full_route    = hardware_event_routing_reg[SEPR_HW_FIFO_FULL];
	assign pin_a_fifo_level_route   = hardware_event_routing_reg[SEPR_HW_FIFO_LEVEL];
	assign pin_a_sample_fresh_route = hardware_event_routing_reg[SEPR_HW_SAMPLE_FRESH];
	assign pin_b_fifo_full_route    = hardware_event_routing_reg[SEPR_HW_PIN_STRIDE + SEPR_HW_FIFO_FULL];
	assign pin_b_fifo_level_route   = hardware_event_routing_reg[SEPR_HW_PIN_STRIDE + SEPR_HW_FIFO_LEVEL];
	assign pin_b_sample_fresh_route = hardware_event_routing_reg[SEPR_HW_PIN_STRIDE + SEPR_HW_SAMPLE_FRESH];

	// Routing fields gathered per pin index
	assign feat_cfg[0] = pin_a_feature_routing_reg;
	assign feat_cfg[1] = pin_b_feature_routing_reg;
	assign hw_cfg[0]   = {pin_a_sample_fresh_route, pin_a_fifo_level_route, pin_a_fifo_full_route};
	assign hw_cfg[1]   = {pin_b_sample_fresh_route, pin_b_fifo_level_route, pin_b_fifo_full_route};

	// Per-pin gating of every source by its route bit
	for (genvar r = 0; r < NUM_PINS; r++)
	begin : g_route
		logic any_mot_hit;
		logic no_mot_hit;
		logic error_hit;
		logic fifo_full_hit;
		logic fifo_level_hit;
		logic sample_fresh_hit;

		// Feature engine sources
		assign any_mot_hit      = feat_cfg[r][SEPR_FEAT_ANY_MOT] & src_any_motion;
		assign no_mot_hit       = feat_cfg[r][SEPR_FEAT_NO_MOT] & src_no_motion;
		assign error_hit        = feat_cfg[r][SEPR_FEAT_ERROR] & src_error;
		// Hardware event sources
		assign fifo_full_hit    = hw_cfg[r][0] & src_fifo_full;
		assign fifo_level_hit   = hw_cfg[r][1] & src_fifo_level;
		assign sample_fresh_hit = hw_cfg[r][2] & src_sample_fresh;

		assign feat_hit[r] = any_mot_hit | no_mot_hit | error_hit;
		assign hw_hit[r]   = fifo_full_hit | fifo_level_hit | sample_fresh_hit;
	end

	// OR of all routed sources, before polarity and drive
	assign feat_any_a = feat_hit | hw_hit;

	// ==========================================================
	// Per-pin hold logic and driver
	logic [NUM_PINS-1:0] hold_reg;
	logic [NUM_PINS-1:0] hold_next;
	logic [NUM_PINS-1:0] hold_keep;
	logic [NUM_PINS-1:0] asserted;
	logic [NUM_PINS-1:0] pin_in_vec;
	logic [NUM_PINS-1:0] pin_out_vec;
	logic [NUM_PINS-1:0] pin_oe_vec;
	logic [NUM_PINS-1:0] in_event_vec;
	logic                latched_mode;

	assign latched_mode = event_hold_mode_reg[SEPR_HOLD_LATCHED];
	assign pin_in_vec   = {event_pin_b_in, event_pin_a_in};

	// Held state survives unless the host read the status
	assign hold_keep = hold_reg & {NUM_PINS{~status_read}};
	// Set wins over the status-read clear; leaving hold mode drops it
	assign hold_next = latched_mode ? (feat_any_a | hold_keep)
		: {NUM_PINS{1'b0}};
	assign asserted  = feat_any_a | hold_reg;

	// Latch storage
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			hold_reg <= '0;
		else
			hold_reg <= hold_next;
	end

	sepr_pin_if pin_if [NUM_PINS] ();

	// One driver per pin with its own io configuration
	for (genvar g = 0; g < NUM_PINS; g++)
	begin : g_pin
		logic [7:0] io_cfg;

		assign io_cfg = (g == 0) ? pin_a_io_config_reg : pin_b_io_config_reg;

		assign pin_if[g].trig_edge         = io_cfg[SEPR_IO_TRIG_EDGE];
		assign pin_if[g].active_high       = io_cfg[SEPR_IO_ACTIVE_HIGH];
		assign pin_if[g].drive_type_select = io_cfg[SEPR_IO_DRIVE_TYPE];
		assign pin_if[g].out_en            = io_cfg[SEPR_IO_OUT_EN];
		assign pin_if[g].in_en             = io_cfg[SEPR_IO_IN_EN];
		assign pin_if[g].asserted          = asserted[g];
		assign pin_if[g].pin_in            = pin_in_vec[g];
		assign pin_out_vec[g]              = pin_if[g].pin_out;
		assign pin_oe_vec[g]               = pin_if[g].pin_oe;
		assign in_event_vec[g]             = pin_if[g].in_event;

		sepr_pin_driver u_drv (
			.clk     (clk),
			.sys_rst (sys_rst),
			.pin     (pin_if[g])
		);
	end

	// Driver outputs are flip-flops inside the pin driver
	assign event_pin_a_out = pin_out_vec[0];
	assign event_pin_a_oe  = pin_oe_vec[0];
	assign pin_a_in_event  = in_event_vec[0];
	assign event_pin_b_out = pin_out_vec[1];
	assign event_pin_b_oe  = pin_oe_vec[1];
	assign pin_b_in_event  = in_event_vec[1];

endmodule

// ### shared/sepr_pkg.sv
package sepr_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] SEPR_OFS_PIN_A_IO      = 8'h53;
	localparam logic [7:0] SEPR_OFS_PIN_B_IO      = 8'h54;
	localparam logic [7:0] SEPR_OFS_HOLD_MODE     = 8'h55;
	localparam logic [7:0] SEPR_OFS_PIN_A_FEATURE = 8'h56;
	localparam logic [7:0] SEPR_OFS_PIN_B_FEATURE = 8'h57;
	localparam logic [7:0] SEPR_OFS_HW_ROUTING    = 8'h58;
	localparam logic [7:0] SEPR_OFS_BOOT_LOAD     = 8'h59;

	// ==========================================================
	// Reset values
	localparam logic [7:0] SEPR_RST_IO        = 8'h00;
	localparam logic [7:0] SEPR_RST_HOLD      = 8'h00;
	localparam logic [7:0] SEPR_RST_FEATURE   = 8'h00;
	localparam logic [7:0] SEPR_RST_HW_ROUTE  = 8'h00;
	localparam logic [7:0] SEPR_RST_BOOT_LOAD = 8'h90;

	// ==========================================================
	// Writable bits; reserved bits read as zero
	localparam logic [7:0] SEPR_MASK_IO        = 8'h1F;
	localparam logic [7:0] SEPR_MASK_HOLD      = 8'h01;
	localparam logic [7:0] SEPR_MASK_FEATURE   = 8'hE0;
	localparam logic [7:0] SEPR_MASK_HW_ROUTE  = 8'h77;
	localparam logic [7:0] SEPR_MASK_BOOT_LOAD = 8'hFF;

	// ==========================================================
	// Field positions, pin io configuration
	localparam int SEPR_IO_TRIG_EDGE   = 0;
	localparam int SEPR_IO_ACTIVE_HIGH = 1;
	localparam int SEPR_IO_DRIVE_TYPE  = 2;
	localparam int SEPR_IO_OUT_EN      = 3;
	localparam int SEPR_IO_IN_EN       = 4;

	// Field positions, hold mode and feature routing
	localparam int SEPR_HOLD_LATCHED   = 0;
	localparam int SEPR_FEAT_ANY_MOT   = 5;
	localparam int SEPR_FEAT_NO_MOT    = 6;
	localparam int SEPR_FEAT_ERROR     = 7;

	// Field positions, hardware event routing (pin b adds the stride)
	localparam int SEPR_HW_FIFO_FULL    = 0;
	localparam int SEPR_HW_FIFO_LEVEL   = 1;
	localparam int SEPR_HW_SAMPLE_FRESH = 2;
	localparam int SEPR_HW_PIN_STRIDE   = 4;

endpackage

// ### shared/sepr_pin_if.sv
// ==========================================================
// Per-pin settings and state between router and pin driver
interface sepr_pin_if;
	logic trig_edge;
	logic active_high;
	logic drive_type_select;
	logic out_en;
	logic in_en;
	logic asserted;
	logic pin_in;
	logic pin_out;
	logic pin_oe;
	logic in_event;

	modport ctrl (
		output trig_edge,
		output active_high,
		output drive_type_select,
		output out_en,
		output in_en,
		output asserted,
		output pin_in,
		input  pin_out,
		input  pin_oe,
		input  in_event
	);

	modport drv (
		input  trig_edge,
		input  active_high,
		input  drive_type_select,
		input  out_en,
		input  in_en,
		input  asserted,
		input  pin_in,
		output pin_out,
		output pin_oe,
		output in_event
	);
endinterface

// ### design/sepr_pin_driver.sv
module sepr_pin_driver
	import sepr_pkg::*;
(
	input  wire logic clk,
	input  wire logic sys_rst,
	sepr_pin_if.drv   pin
);

	// ==========================================================
	// Output stage
	logic active_level;
	logic drive_now;
	logic pin_out_reg;
	logic pin_oe_reg;

	// Active level follows polarity
	assign active_level = pin.asserted ? pin.active_high : ~pin.active_high;
	// Open drain never drives the inactive level
	assign drive_now = pin.out_en & (pin.asserted | ~pin.drive_type_select);

	// Register pin drive
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			pin_out_reg <= 1'b0;
			pin_oe_reg  <= 1'b0;
		end
		else
		begin
			pin_out_reg <= active_level;
			pin_oe_reg  <= drive_now;
		end
	end

	assign pin.pin_out = pin_out_reg;
	assign pin.pin_oe  = pin_oe_reg;

	// ==========================================================
	// Input stage
	logic at_active;
	logic prev_reg;
	logic in_event_reg;
	logic in_event_next;

	// Pin level seen at its configured active polarity
	assign at_active = pin.pin_in ~^ pin.active_high;
	// Level or rising-into-active edge, only while input enabled
	assign in_event_next = pin.in_en & (pin.trig_edge ? (at_active & ~prev_reg) : at_active);

	// Register input sampling
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			prev_reg     <= 1'b0;
			in_event_reg <= 1'b0;
		end
		else
		begin
			prev_reg     <= pin.in_en & at_active;
			in_event_reg <= in_event_next;
		end
	end

	assign pin.in_event = in_event_reg;

endmodule

// ### test/sepr_router_sva.sv
module sepr_router_sva
	import sepr_pkg::*;
(
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic       src_any_motion,
	input wire logic       src_no_motion,
	input wire logic       src_error,
	input wire logic       src_fifo_full,
	input wire logic       src_fifo_level,
	input wire logic       src_sample_fresh,
	input wire logic       status_read,
	input wire logic       event_pin_a_in,
	input wire logic       event_pin_a_out,
	input wire logic       event_pin_a_oe,
	input wire logic       pin_a_in_event,
	input wire logic       event_pin_b_out,
	input wire logic       boot_start,
	input wire logic [7:0] boot_load_value
);
	// ========
	// Shadow configuration
	logic [7:0] io_a;
	logic [7:0] io_b;
	logic [7:0] hold;
	logic [7:0] fa;
	logic [7:0] fb;
	logic [7:0] hw;
	logic [1:0] age;
	logic [5:0] src;
	logic       or_a;
	logic       or_b;
	// Routed sources ORed per pin
	assign src  = {src_sample_fresh, src_fifo_level, src_fifo_full, src_error, src_no_motion, src_any_motion};
	assign or_a = |(fa[7:5] & src[2:0]) | |(hw[2:0] & src[5:3]);
	assign or_b = |(fb[7:5] & src[2:0]) | |(hw[6:4] & src[5:3]);
	// Track writes and cycles since reset
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			{io_a, io_b, hold, fa, fb, hw} <= '0;
			age <= 2'h0;
		end
		else
		begin
			age <= (age == 2'h2) ? age : age + 2'h1;
			if (reg_wr && reg_addr == SEPR_OFS_PIN_A_IO) io_a <= reg_wdata & SEPR_MASK_IO;
			if (reg_wr && reg_addr == SEPR_OFS_PIN_B_IO) io_b <= reg_wdata & SEPR_MASK_IO;
			if (reg_wr && reg_addr == SEPR_OFS_HOLD_MODE) hold <= reg_wdata & SEPR_MASK_HOLD;
			if (reg_wr && reg_addr == SEPR_OFS_PIN_A_FEATURE) fa <= reg_wdata & SEPR_MASK_FEATURE;
			if (reg_wr && reg_addr == SEPR_OFS_PIN_B_FEATURE) fb <= reg_wdata & SEPR_MASK_FEATURE;
			if (reg_wr && reg_addr == SEPR_OFS_HW_ROUTING) hw <= reg_wdata & SEPR_MASK_HW_ROUTE;
		end
	end
	// ========
	// Properties
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	sequence s_clear_a;
		age == 2'h2 && hold[0] && $past(hold[0]) && status_read && !or_a && $stable(io_a) ##1 !or_a && $stable(io_a);
	endsequence
	a_boot_pulse: assert property (reg_wr && reg_addr == SEPR_OFS_BOOT_LOAD |=>
		boot_start && boot_load_value == $past(reg_wdata)) else $error("boot write not seen");
	a_oe_off: assert property (!$past(io_a[3]) |-> !event_pin_a_oe)
		else $error("driver on while disabled");
	a_od_level: assert property ($past(io_a[2]) && event_pin_a_oe |-> event_pin_a_out == $past(io_a[1]))
		else $error("open drain drove inactive level");
	a_route_a: assert property (age == 2'h2 && !$past(hold[0]) && !$past(hold[0], 2) |->
		event_pin_a_out == ($past(or_a) ~^ $past(io_a[1]))) else $error("pin a level wrong");
	a_route_b: assert property (age == 2'h2 && !$past(hold[0]) && !$past(hold[0], 2) |->
		event_pin_b_out == ($past(or_b) ~^ $past(io_b[1]))) else $error("pin b level wrong");
	a_latch_keep: assert property (age == 2'h2 && hold[0] && $past(hold[0]) && $past(hold[0], 2)
		&& !$past(status_read) && $stable(io_a) && event_pin_a_out == io_a[1] |=> event_pin_a_out == $past(io_a[1]))
		else $error("latched pin dropped");
	a_latch_clear: assert property (s_clear_a |=> event_pin_a_out == !$past(io_a[1]))
		else $error("latched pin not released");
	a_in_level: assert property ($past(io_a[4]) && !$past(io_a[0]) |->
		pin_a_in_event == ($past(event_pin_a_in) == $past(io_a[1]))) else $error("level input wrong");
	a_in_edge: assert property ($past(io_a[0]) && $past(io_a[4]) && $past(io_a) == $past(io_a, 2) && pin_a_in_event
		|-> $past(event_pin_a_in) == $past(io_a[1]) && $past(event_pin_a_in, 2) != $past(io_a[1]))
		else $error("edge input pulse wrong");
endmodule
bind sepr_router sepr_router_sva u_sva (.clk, .sys_rst, .reg_addr, .reg_wr, .reg_wdata, .src_any_motion,
	.src_no_motion, .src_error, .src_fifo_full, .src_fifo_level, .src_sample_fresh, .status_read, .event_pin_a_in,
	.event_pin_a_out, .event_pin_a_oe, .pin_a_in_event, .event_pin_b_out, .boot_start, .boot_load_value);

// ### test/sepr_host_model.sv
module sepr_host_model
(
	input  wire logic clk,
	input  wire logic pin_out,
	input  wire logic pin_oe,
	input  wire logic drv_en,
	input  wire logic drv_val,
	input  wire logic ack_req,
	output logic      wire_lvl,
	output logic      status_read
);
	timeunit 1ns;
	timeprecision 1ps;
	// Wire: device drive, else host drive, else pull-up
	assign wire_lvl = pin_oe ? pin_out : (drv_en ? drv_val : 1'b1);
	// Host reads event status one cycle after asking
	initial status_read = 1'b0;
	always @(posedge clk)
		status_read <= ack_req;
endmodule

// ### test/sensor_event_pin_router_tb_top.sv
module sensor_event_pin_router_tb_top
	import sepr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [1:0] sel; logic [7:0] exp;} sepr_note_t;
	localparam logic [7:0] OFS [7] = '{8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h58, 8'h59};
	localparam logic [7:0] MSK [7] = '{8'h1F, 8'h1F, 8'h01, 8'hE0, 8'hE0, 8'h77, 8'hFF};
	localparam logic [7:0] RST [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h90};
	logic       clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [5:0] src = 6'h00;
	logic       look = 1'b0;
	logic       ack_req = 1'b0;
	logic       drv_en = 1'b0;
	logic       drv_val = 1'b0;
	logic [7:0] reg_rdata, boot_load_value;
	logic       status_read, event_pin_a_in, event_pin_a_out, event_pin_a_oe, pin_a_in_event;
	logic       event_pin_b_in, event_pin_b_out, event_pin_b_oe, pin_b_in_event;
	logic [7:0] obs [4];
	int         mismatches = 0;
	int         n_checks = 0;
	sepr_note_t notes[$];
	sepr_router DUT (.clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
		.src_any_motion(src[0]), .src_no_motion(src[1]), .src_error(src[2]), .src_fifo_full(src[3]),
		.src_fifo_level(src[4]), .src_sample_fresh(src[5]), .status_read, .event_pin_a_in, .event_pin_a_out,
		.event_pin_a_oe, .pin_a_in_event, .event_pin_b_in, .event_pin_b_out, .event_pin_b_oe, .pin_b_in_event,
		.boot_start(), .boot_load_value);
	sepr_host_model host (.clk, .pin_out(event_pin_a_out), .pin_oe(event_pin_a_oe), .drv_en, .drv_val,
		.ack_req, .wire_lvl(event_pin_a_in), .status_read);
	// Pin b wire with pull-up; observed words
	assign event_pin_b_in = event_pin_b_oe ? event_pin_b_out : 1'b1;
	assign obs[0] = reg_rdata;
	assign obs[1] = {4'h0, event_pin_a_oe, event_pin_a_out, event_pin_a_in, pin_a_in_event};
	assign obs[2] = {4'h0, event_pin_b_oe, event_pin_b_out, event_pin_b_in, pin_b_in_event};
	assign obs[3] = boot_load_value;
	always #12.5 clk = ~clk;
	// Compare each result with the oldest note
	always @(negedge clk)
	begin
		sepr_note_t n;
		if (look)
		begin
			n = notes.pop_front();
			n_checks++;
			if (obs[n.sel] !== n.exp)
			begin
				mismatches++;
				$display("MISMATCH %0t sel %0d got %h exp %h", $time, n.sel, obs[n.sel], n.exp);
			end
		end
	end
	task automatic note(logic [1:0] s, logic [7:0] e, int k = 2);
		repeat (k) @(posedge clk);
		notes.push_back('{s, e});
		look <= 1'b1;
		@(posedge clk);
		look <= 1'b0;
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		@(posedge clk);
		{reg_rd, reg_addr} <= {1'b1, a};
		@(posedge clk);
		reg_rd <= 1'b0;
		note(2'h0, e);
	endtask
	task automatic ack();
		@(posedge clk);
		ack_req <= 1'b1;
		@(posedge clk);
		ack_req <= 1'b0;
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Watchdog
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		results();
	end
	// Main sequence
	initial
	begin
		logic [7:0] d;
		logic       l;
		logic       oe;
		logic       o;
		void'($urandom(6));
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 7; i++)
			rd(OFS[i], RST[i]);
		for (int i = 0; i < 7; i++)
		begin
			d = 8'($urandom);
			wr(OFS[i], d);
			rd(OFS[i], d & MSK[i]);
		end
		note(2'h3, d);
		wr(8'h5A, 8'hFF);
		rd(8'h5A, 8'h00);
		rd(8'h52, 8'h00);
		$display("test registers done");
		wr(SEPR_OFS_HOLD_MODE, 8'h00);
		wr(SEPR_OFS_PIN_A_IO, 8'h0A);
		wr(SEPR_OFS_PIN_B_IO, 8'h0A);
		for (int i = 0; i < 12; i++)
		begin
			wr(SEPR_OFS_PIN_A_FEATURE, (i < 6 && i % 2 == 0) ? 8'(8'h20 << (i / 2)) : 8'h00);
			wr(SEPR_OFS_PIN_B_FEATURE, (i < 6 && i % 2 == 1) ? 8'(8'h20 << (i / 2)) : 8'h00);
			wr(SEPR_OFS_HW_ROUTING, (i >= 6) ? 8'(8'h01 << (i / 2 - 3 + 4 * (i % 2))) : 8'h00);
			@(posedge clk) src <= 6'(6'h01 << (i / 2));
			note(2'h1, (i % 2 == 0) ? 8'h0E : 8'h08);
			note(2'h2, (i % 2 == 1) ? 8'h0E : 8'h08);
			@(posedge clk) src <= ~6'(6'h01 << (i / 2));
			note(2'h1, 8'h08);
			note(2'h2, 8'h08);
		end
		$display("test routing done");
		wr(SEPR_OFS_PIN_A_FEATURE, 8'h20);
		for (int i = 0; i < 16; i++)
		begin
			d = {4'h0, i[3:1], 1'b0};
			wr(SEPR_OFS_PIN_A_IO, d);
			@(posedge clk) src <= {5'h00, i[0]};
			o = i[0] ? d[1] : !d[1];
			oe = d[3] && (!d[2] || i[0]);
			note(2'h1, {4'h0, oe, o, oe ? o : 1'b1, 1'b0});
		end
		$display("test drive done");
		wr(SEPR_OFS_PIN_A_IO, 8'h0A);
		wr(SEPR_OFS_HOLD_MODE, 8'h01);
		@(posedge clk) src <= 6'h01;
		@(posedge clk) src <= 6'h00;
		note(2'h1, 8'h0E, 5);
		ack();
		note(2'h1, 8'h08, 3);
		@(posedge clk) src <= 6'h01;
		ack();
		note(2'h1, 8'h0E, 3);
		@(posedge clk) src <= 6'h00;
		note(2'h1, 8'h0E, 3);
		ack();
		note(2'h1, 8'h08, 3);
		wr(SEPR_OFS_HOLD_MODE, 8'h00);
		$display("test latch done");
		drv_en <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			l = i[0];
			wr(SEPR_OFS_PIN_A_IO, {3'h0, 1'b1, 2'h0, l, i[1]});
			@(posedge clk) drv_val <= !l;
			note(2'h1, {5'h00, !l, !l, 1'b0});
			@(posedge clk) drv_val <= l;
			note(2'h1, {5'h00, !l, l, 1'b1}, 1);
			note(2'h1, {5'h00, !l, l, !i[1]}, 1);
		end
		wr(SEPR_OFS_PIN_A_IO, 8'h02);
		note(2'h1, 8'h02);
		wr(SEPR_OFS_PIN_B_IO, 8'h12);
		note(2'h2, 8'h03);
		$display("test input done");
		results();
	end
endmodule
